// ===== rtl/crtc_top.sv
// Receive timing configuration and checking for a single-wire control bus line.
// Assumes an AXI4-Lite master on aclk and an open-drain line outside.
`timescale 1ns/1ps
module crtc_top #(
	parameter int ERR_LOW_CYCLES = crtc_pkg::ERR_LOW_CYC,
	parameter int SAMPLE_DIV     = crtc_pkg::FS_DIV
) (
	// Clock and reset
	input  wire logic       aclk,
	input  wire logic       aresetn,
	// AXI4-Lite write
	input  wire logic [7:0] awaddr,
	input  wire logic       awvalid,
	output logic            awready,
	input  wire logic [31:0] wdata,
	input  wire logic [3:0] wstrb,
	input  wire logic       wvalid,
	output logic            wready,
	output logic [1:0]      bresp,
	output logic            bvalid,
	input  wire logic       bready,
	// AXI4-Lite read
	input  wire logic [7:0] araddr,
	input  wire logic       arvalid,
	output logic            arready,
	output logic [31:0]     rdata,
	output logic [1:0]      rresp,
	output logic            rvalid,
	input  wire logic       rready,
	// Bus line
	input  wire logic       cec_in,
	output logic            cec_out,
	output logic            cec_oe_n,
	output logic            tx_ack_sample,
	// Interrupt
	output logic            irq
);
	import crtc_pkg::*;

	// ****************************************
	// Helpers
	// ****************************************
	function automatic logic [7:0] lim(input logic [7:0] base, input logic [2:0] code);
		lim = code[2] ? base - {6'h00, code[1:0]} - 8'h01 : base + {6'h00, code[1:0]};
	endfunction

	function automatic logic [31:0] wmerge(input logic [31:0] old, input logic [31:0] nw,
		input logic [3:0] strb);
		for (int i = 0; i < 4; i++) begin
			wmerge[i*8 +: 8] = strb[i] ? nw[i*8 +: 8] : old[i*8 +: 8];
		end
	endfunction

	// ****************************************
	// Registers and state
	// ****************************************
	logic [31:0]        rcr1;
	logic [15:0]        addr_set;
	logic               rx_en;
	logic [STAT_W-1:0]  stat;
	logic [STAT_W-1:0]  mask;
	logic [9:0]         rx_data;
	logic [7:0]         aw_q;
	logic [31:0]        w_q;
	logic [3:0]         ws_q;
	logic [9:0]         div_cnt;
	logic               sample_en;
	logic [7:0]         per_cnt;
	logic [3:0]         bit_idx;
	logic [8:0]         sh;
	logic               hdr;
	logic               addressed;
	logic               ack_on;
	logic [31:0]        err_cnt;
	crtc_state_type     state;

	crtc_filt_if fi (.aclk(aclk));

	crtc_glitch_filter u_filt (
		.aclk    (aclk),
		.aresetn (aresetn),
		.fi      (fi)
	);

	// Reserved low codes fold onto their two low bits
	assign fi.sample_en = sample_en;
	assign fi.raw       = cec_in;
	assign fi.hnc       = rcr1[HNC_LSB +: 2];
	assign fi.lnc       = rcr1[LNC_LSB +: 2];

	// ****************************************
	// Decoding
	// ****************************************
	wire        lvl       = fi.level;
	wire        fall      = fi.fall;
	wire        ackdis    = rcr1[ACKDIS_POS];
	wire  [7:0] min_lim   = lim(MIN_BASE, rcr1[MIN_LSB +: 3]);
	wire  [7:0] max_lim   = lim(MAX_BASE, rcr1[MAX_LSB +: 3]);
	wire        st_bit    = state == ST_BIT;
	wire        bit_fall  = rx_en && st_bit && fall;
	wire        short_bit = bit_fall && per_cnt < min_lim;
	wire        into_ack  = bit_fall && !short_bit && bit_idx == LAST_BIT - 4'h1;
	wire        hdr_match = addr_set[sh[4:1]];
	wire        ack_want  = hdr ? hdr_match : (addressed && !ackdis);
	wire        max_hit   = rx_en && st_bit && sample_en && per_cnt == max_lim;
	wire        dpoint    = rx_en && st_bit && sample_en && per_cnt == DATA_POINT;
	wire        blk_end   = dpoint && bit_idx == LAST_BIT;
	wire        err_done  = err_cnt == 32'(ERR_LOW_CYCLES - 1);

	wire        wr_fire   = !awready && !wready && !bvalid;
	wire        wr_rcr1   = wr_fire && aw_q == OFF_RCR1;
	wire        wr_addr   = wr_fire && aw_q == OFF_ADDR;
	wire        wr_ren    = wr_fire && aw_q == OFF_REN;
	wire        wr_stat   = wr_fire && aw_q == OFF_STAT;
	wire        wr_mask   = wr_fire && aw_q == OFF_MASK;
	wire        wr_ok     = wr_rcr1 || wr_addr || wr_ren || wr_stat || wr_mask ||
		(wr_fire && aw_q == OFF_RXDATA);
	wire [31:0] rcr1_wr   = wmerge(rcr1, w_q, ws_q) & RCR1_WMASK;
	wire [31:0] addr_wr   = wmerge({16'h0000, addr_set}, w_q, ws_q);
	wire [STAT_W-1:0] stat_clr = (wr_stat && ws_q[0]) ? w_q[STAT_W-1:0] : '0;
	wire [STAT_W-1:0] stat_set = {blk_end, max_hit, short_bit};
	wire [STAT_W-1:0] next_stat = (stat & ~stat_clr) | stat_set;
	// Interrupt follows a mask write in the same cycle as the mask itself
	wire [STAT_W-1:0] next_mask = (wr_mask && ws_q[0]) ? w_q[STAT_W-1:0] : mask;

	wire        rd_hit    = araddr == OFF_RCR1 || araddr == OFF_ADDR ||
		araddr == OFF_REN || araddr == OFF_STAT || araddr == OFF_MASK ||
		araddr == OFF_RXDATA;
	wire [31:0] rd_mux    =
		(araddr == OFF_RCR1)   ? rcr1 :
		(araddr == OFF_ADDR)   ? {16'h0000, addr_set} :
		(araddr == OFF_REN)    ? {31'h0000_0000, rx_en} :
		(araddr == OFF_STAT)   ? {29'h0000_0000, stat} :
		(araddr == OFF_MASK)   ? {29'h0000_0000, mask} :
		(araddr == OFF_RXDATA) ? {22'h00_0000, rx_data} : 32'h0000_0000;

	// ****************************************
	// AXI4-Lite slave
	// ****************************************
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			awready <= 1'b1;
			wready  <= 1'b1;
			bvalid  <= 1'b0;
			bresp   <= RESP_OKAY;
			aw_q    <= 8'h00;
			w_q     <= 32'h0000_0000;
			ws_q    <= 4'h0;
		end else begin
			if (awvalid && awready) begin
				aw_q    <= awaddr;
				awready <= 1'b0;
			end
			if (wvalid && wready) begin
				w_q    <= wdata;
				ws_q   <= wstrb;
				wready <= 1'b0;
			end
			if (wr_fire) begin
				bvalid <= 1'b1;
				bresp  <= wr_ok ? RESP_OKAY : RESP_SLVERR;
			end
			if (bvalid && bready) begin
				bvalid  <= 1'b0;
				awready <= 1'b1;
				wready  <= 1'b1;
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			arready <= 1'b1;
			rvalid  <= 1'b0;
			rdata   <= 32'h0000_0000;
			rresp   <= RESP_OKAY;
		end else if (arvalid && arready) begin
			arready <= 1'b0;
			rvalid  <= 1'b1;
			rdata   <= rd_mux;
			rresp   <= rd_hit ? RESP_OKAY : RESP_SLVERR;
		end else if (rvalid && rready) begin
			rvalid  <= 1'b0;
			arready <= 1'b1;
		end
	end

	// ****************************************
	// Software registers
	// ****************************************
	// Settings are taken as written; changing them mid-frame is not guarded
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rcr1     <= RCR1_RESET;
			addr_set <= ADDR_RESET;
			rx_en    <= 1'b0;
			mask     <= '0;
		end else begin
			if (wr_rcr1) begin
				rcr1 <= rcr1_wr;
			end
			if (wr_addr) begin
				addr_set <= addr_wr[15:0];
			end
			if (wr_ren && ws_q[0]) begin
				rx_en <= w_q[0];
			end
			if (wr_mask && ws_q[0]) begin
				mask <= w_q[STAT_W-1:0];
			end
		end
	end

	// Set wins over a write-one clear in the same cycle
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			stat <= '0;
			irq  <= 1'b0;
		end else begin
			stat <= next_stat;
			irq  <= |(next_stat & next_mask);
		end
	end

	// ****************************************
	// Sampling clock enable
	// ****************************************
	// Integer divide runs the sampling clock slightly fast; all limits but the error low (counted in aclk) scale with it
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			div_cnt   <= 10'h000;
			sample_en <= 1'b0;
		end else begin
			sample_en <= div_cnt == 10'(SAMPLE_DIV - 1);
			div_cnt   <= (div_cnt == 10'(SAMPLE_DIV - 1)) ? 10'h000 : div_cnt + 10'h001;
		end
	end

	// Period counter restarts at each filtered fall and saturates
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			per_cnt <= 8'h00;
		end else if (fall) begin
			per_cnt <= 8'h00;
		end else if (sample_en && per_cnt != 8'hFF) begin
			per_cnt <= per_cnt + 8'h01;
		end
	end

	// ****************************************
	// Receive sequencer
	// ****************************************
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			state     <= ST_IDLE;
			bit_idx   <= 4'h0;
			sh        <= 9'h000;
			hdr       <= 1'b0;
			addressed <= 1'b0;
			ack_on    <= 1'b0;
			err_cnt   <= 32'h0000_0000;
			rx_data   <= 10'h000;
		end else if (!rx_en) begin
			state  <= ST_IDLE;
			ack_on <= 1'b0;
		end else begin
			case (state)
				ST_IDLE: begin
					if (sample_en && !lvl && per_cnt == START_LOW) begin
						state <= ST_START;
					end
				end
				ST_START: begin
					if (fall) begin
						state   <= ST_BIT;
						bit_idx <= 4'h0;
						hdr     <= 1'b1;
					end else if (per_cnt == 8'hFF) begin
						state <= ST_IDLE;
					end
				end
				ST_BIT: begin
					if (short_bit) begin
						state   <= ST_ERRLOW;
						err_cnt <= 32'h0000_0000;
						ack_on  <= 1'b0;
					end else if (max_hit) begin
						state  <= ST_IDLE;
						ack_on <= 1'b0;
					end else if (fall) begin
						bit_idx <= (bit_idx == LAST_BIT) ? 4'h0 : bit_idx + 4'h1;
						ack_on  <= into_ack && ack_want;
					end else begin
						if (sample_en && per_cnt == ACK_LOW) begin
							ack_on <= 1'b0;
						end
						if (dpoint) begin
							sh <= {sh[7:0], lvl};
						end
						if (blk_end) begin
							rx_data <= {lvl, sh[0], sh[8:1]};
							hdr     <= 1'b0;
							if (hdr) begin
								addressed <= hdr_match;
							end
							if (sh[0]) begin
								state <= ST_IDLE;
							end
						end
					end
				end
				ST_ERRLOW: begin
					err_cnt <= err_cnt + 32'h0000_0001;
					if (err_done) begin
						state <= ST_IDLE;
					end
				end
				default: begin
					state <= ST_IDLE;
				end
			endcase
		end
	end

	// ****************************************
	// Line drive
	// ****************************************
	// Drive follows the sequencer by one aclk, far below a sampling period
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			cec_out       <= 1'b0;
			cec_oe_n      <= 1'b1;
			tx_ack_sample <= 1'b1;
		end else begin
			cec_out       <= 1'b0;
			cec_oe_n      <= !(ack_on || state == ST_ERRLOW);
			tx_ack_sample <= lvl;
		end
	end

	// ****************************************
	// Assertions
	// ****************************************
	property p_data_ack;
		@(posedge aclk) disable iff (!aresetn)
		(into_ack && !hdr && addressed && !ackdis) |=> ack_on ##1 !cec_oe_n;
	endproperty
	a_data_ack: assert property (p_data_ack) else $error("data ack not driven");

	property p_data_nack;
		@(posedge aclk) disable iff (!aresetn)
		(into_ack && !hdr && ackdis) |=> !ack_on;
	endproperty
	a_data_nack: assert property (p_data_nack) else $error("suppressed ack driven");

	property p_hdr_ack;
		@(posedge aclk) disable iff (!aresetn)
		(into_ack && hdr && hdr_match) |=> ack_on ##1 !cec_oe_n;
	endproperty
	a_hdr_ack: assert property (p_hdr_ack) else $error("header ack missing");

	property p_min_err;
		@(posedge aclk) disable iff (!aresetn)
		short_bit |=> stat[ST_MIN_BIT] && state == ST_ERRLOW ##1 !cec_oe_n[*8];
	endproperty
	a_min_err: assert property (p_min_err) else $error("short bit not flagged");

	property p_min_ok;
		@(posedge aclk) disable iff (!aresetn)
		(bit_fall && per_cnt >= lim(MIN_BASE, rcr1[MIN_LSB +: 3])) |=> state != ST_ERRLOW;
	endproperty
	a_min_ok: assert property (p_min_ok) else $error("valid bit flagged short");

	property p_err_len;
		@(posedge aclk) disable iff (!aresetn)
		(state == ST_ERRLOW && err_cnt < 32'(ERR_LOW_CYCLES - 1) && rx_en) |=>
			state == ST_ERRLOW;
	endproperty
	a_err_len: assert property (p_err_len) else $error("error low cut short");

	property p_max_err;
		@(posedge aclk) disable iff (!aresetn)
		(rx_en && st_bit && sample_en && per_cnt == (rcr1[MAX_LSB + 2] ?
			MAX_BASE - 8'(rcr1[MAX_LSB +: 2]) - 8'h01 : MAX_BASE + 8'(rcr1[MAX_LSB +: 2])))
			|=> stat[ST_MAX_BIT] && state == ST_IDLE;
	endproperty
	a_max_err: assert property (p_max_err) else $error("long bit not flagged");

	property p_restart;
		@(posedge aclk) disable iff (!aresetn)
		fall |=> per_cnt == 8'h00;
	endproperty
	a_restart: assert property (p_restart) else $error("period count not restarted");

	property p_irq;
		@(posedge aclk) disable iff (!aresetn)
		irq == ((stat & mask) != '0);
	endproperty
	a_irq: assert property (p_irq) else $error("interrupt not raised");

	c_ack: cover property (@(posedge aclk) disable iff (!aresetn) into_ack && ack_want);
	c_min: cover property (@(posedge aclk) disable iff (!aresetn) short_bit);
	c_max: cover property (@(posedge aclk) disable iff (!aresetn) max_hit);
	c_blk: cover property (@(posedge aclk) disable iff (!aresetn) blk_end && sh[0]);

endmodule // crtc_top

// ===== rtl/crtc_pkg.sv
// Constants, register map and types of the receive timing configuration block.
// Assumes a 25 MHz aclk and a sampling clock of about 32.768 kHz derived from it.
package crtc_pkg;

	// ****************************************
	// Register offsets (byte addresses)
	// ****************************************
	localparam logic [7:0]  OFF_RCR1    = 8'h00;
	localparam logic [7:0]  OFF_ADDR    = 8'h04;
	localparam logic [7:0]  OFF_REN     = 8'h08;
	localparam logic [7:0]  OFF_STAT    = 8'h0C;
	localparam logic [7:0]  OFF_MASK    = 8'h10;
	localparam logic [7:0]  OFF_RXDATA  = 8'h14;

	// ****************************************
	// Field positions and reset values
	// ****************************************
	localparam int          ACKDIS_POS  = 24;
	localparam int          HNC_LSB     = 20;
	localparam int          LNC_LSB     = 16;
	localparam int          MIN_LSB     = 12;
	localparam int          MAX_LSB     = 8;
	localparam logic [31:0] RCR1_WMASK  = 32'h0137_7700;
	localparam logic [31:0] RCR1_RESET  = 32'h0000_0000;
	localparam logic [15:0] ADDR_RESET  = 16'h0000;
	localparam int          STAT_W      = 3;
	localparam int          ST_MIN_BIT  = 0;
	localparam int          ST_MAX_BIT  = 1;
	localparam int          ST_RX_BIT   = 2;
	localparam logic [1:0]  RESP_OKAY   = 2'h0;
	localparam logic [1:0]  RESP_SLVERR = 2'h2;

	// ****************************************
	// Timing
	// ****************************************
	localparam int          CLK_HZ      = 25_000_000;
	localparam int          CLK_MHZ     = 25;
	localparam int          FS_HZ       = 32768;
	localparam int          FS_DIV      = CLK_HZ / FS_HZ;
	localparam int          ERR_LOW_US  = 3630;
	localparam int          ERR_LOW_CYC = ERR_LOW_US * CLK_MHZ;
	localparam logic [7:0]  MIN_BASE    = 8'h43;
	localparam logic [7:0]  MAX_BASE    = 8'h5A;
	localparam logic [7:0]  DATA_POINT  = 8'h22;
	localparam logic [7:0]  ACK_LOW     = 8'h31;
	localparam logic [7:0]  START_LOW   = 8'h6E;
	localparam logic [3:0]  LAST_BIT    = 4'h9;

	typedef enum logic [3:0] {
		ST_IDLE   = 4'b0001,
		ST_START  = 4'b0010,
		ST_BIT    = 4'b0100,
		ST_ERRLOW = 4'b1000
	} crtc_state_type;

endpackage

// ===== rtl/crtc_filt_if.sv
// Interface between the receive controller and its line glitch filter.
// Assumes both ends run on aclk.
`timescale 1ns/1ps
interface crtc_filt_if (
	input wire logic aclk
);
	logic       sample_en;
	logic       raw;
	logic [1:0] hnc;
	logic [1:0] lnc;
	logic       level;
	logic       fall;

	modport ctrl (output sample_en, output raw, output hnc, output lnc,
		input level, input fall);
	modport filt (input sample_en, input raw, input hnc, input lnc,
		output level, output fall);
endinterface

// ===== rtl/crtc_glitch_filter.sv
// Glitch filter for the bus line, counted in sampling-clock periods.
// Assumes raw is synchronous to aclk and sample_en is a one-cycle pulse.
`timescale 1ns/1ps
module crtc_glitch_filter (
	// Clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// Filter link
	crtc_filt_if.filt fi
);
	import crtc_pkg::*;

	logic [1:0] cnt;
	logic       level;
	logic       fall;
	wire        differ = fi.raw != level;
	wire  [1:0] need   = level ? fi.lnc : fi.hnc;
	wire        done   = differ && (cnt == need);

	assign fi.level = level;
	assign fi.fall  = fall;

	// Shorter runs than the selected count never reach the output
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			level <= 1'b1;
			cnt   <= 2'h0;
			fall  <= 1'b0;
		end else begin
			fall <= 1'b0;
			if (fi.sample_en) begin
				if (!differ) begin
					cnt <= 2'h0;
				end else if (done) begin
					level <= fi.raw;
					cnt   <= 2'h0;
					fall  <= level;
				end else begin
					cnt <= cnt + 2'h1;
				end
			end
		end
	end

	property p_filt_change;
		@(posedge aclk) disable iff (!aresetn)
		(level != $past(level)) |-> $past(fi.sample_en) && $past(done);
	endproperty
	a_filt_change: assert property (p_filt_change) else $error("level moved without full run");

	property p_filt_low;
		@(posedge aclk) disable iff (!aresetn)
		(fi.sample_en && differ && level && cnt < fi.lnc) |=> level;
	endproperty
	a_filt_low: assert property (p_filt_low) else $error("short low passed filter");

endmodule // crtc_glitch_filter

// ===== verification/crtc_line_model.sv
// Far-side node of the bus line, acting as an initiator that sends bits.
// Assumes the testbench resolves the wired line from every driver, with a pull-up.
`timescale 1ns/1ps
module crtc_line_model
	import crtc_pkg::*;
#(
	parameter int DIV = FS_DIV
) (
	// Clock
	input  wire logic aclk,
	// Line
	input  wire logic line,
	output logic      drv
);
	initial drv = 1'b1;

	// Hold one level for n sampling periods; 1 releases the line
	task automatic level(input logic v, input int n);
		drv <= v;
		repeat (n * DIV) @(posedge aclk);
	endtask

	// One bit; seen is the wired level at the data point
	task automatic bit_s(input int low, input int per, output logic seen);
		for (int i = 0; i < per; i++) begin
			drv <= (i < low) ? 1'b0 : 1'b1;
			repeat (DIV) @(posedge aclk);
			if (i == int'(DATA_POINT)) seen = line;
		end
	endtask

	// A block: byte MSB first, end-of-message, then an ack bit sent as a 1 (20 periods low)
	task automatic blk(input logic [7:0] b, input logic eom, output logic ack);
		logic s;
		for (int i = 7; i >= 0; i--) bit_s(b[i] ? 20 : 49, 75, s);
		bit_s(eom ? 20 : 49, 75, s);
		bit_s(20, 75, ack);
	endtask
endmodule // crtc_line_model

// ===== verification/tb_top.sv
// Self-checking bench: AXI4-Lite register access plus a far-side line model.
// Assumes the design pulls the open-drain line low while cec_oe_n is low.
`timescale 1ns/1ps
module tb_top;
	import crtc_pkg::*;
	// Short sampling period and error low keep whole frames within the run budget
	localparam int ERR_CYC = 40;
	localparam int SDIV = 4;
	logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, drv, s, ack_prev;
	logic awready, wready, bvalid, arready, rvalid, cec_out, cec_oe_n, tx_ack_sample, irq;
	logic [7:0]  awaddr, araddr;
	logic [31:0] wdata, rdata;
	logic [3:0]  wstrb;
	logic [1:0]  bresp, rresp;
	int          bad_count, checks, tx_edges, runs, run, last_run, e0;
	wire logic   line = drv & (cec_oe_n | cec_out);

	crtc_top #(.ERR_LOW_CYCLES(ERR_CYC), .SAMPLE_DIV(SDIV)) uut (.aclk, .aresetn, .awaddr,
		.awvalid, .awready, .wdata, .wstrb, .wvalid, .wready, .bresp, .bvalid, .bready,
		.araddr, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready, .cec_in(line), .cec_out,
		.cec_oe_n, .tx_ack_sample, .irq);
	crtc_line_model #(.DIV(SDIV)) mdl (.aclk, .line, .drv);

	initial begin
		aclk = 1'b0;
		forever #20 aclk = ~aclk;
	end

	// Line monitors: filtered level changes and length of each pulled-low run
	always @(posedge aclk) begin
		if (tx_ack_sample !== ack_prev) tx_edges++;
		ack_prev = tx_ack_sample;
		if (cec_oe_n === 1'b0) run++;
		else if (run != 0) begin
			last_run = run;
			runs++;
			run = 0;
		end
	end

	task automatic conclude();
		if (bad_count == 0 && checks > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask

	task automatic cmp(input string what, input logic [31:0] exp, input logic [31:0] got);
		checks++;
		if (got !== exp) begin
			bad_count++;
			$display("[ERR] %s exp %h got %h", what, exp, got);
		end
	endtask

	task automatic axw(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
		int n;
		@(posedge aclk);
		n = 0;
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do begin
			@(posedge aclk);
			if (awready === 1'b1) awvalid <= 1'b0;
			if (wready === 1'b1) wvalid <= 1'b0;
			n++;
		end while (bvalid !== 1'b1 && n < 100);
		r = bresp;
		bready <= 1'b0;
		if (n >= 100) begin
			bad_count++;
			conclude();
		end
	endtask

	task automatic axr(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		int n;
		@(posedge aclk);
		n = 0;
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do begin
			@(posedge aclk);
			if (arready === 1'b1) arvalid <= 1'b0;
			n++;
		end while (rvalid !== 1'b1 && n < 100);
		d = rdata;
		r = rresp;
		rready <= 1'b0;
		if (n >= 100) begin
			bad_count++;
			conclude();
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [1:0] r;
		axw(a, d, r);
		cmp("bresp", 32'(RESP_OKAY), 32'(r));
	endtask

	task automatic rchk(input string w, input logic [7:0] a, input logic [31:0] e);
		logic [31:0] d;
		logic [1:0]  r;
		axr(a, d, r);
		cmp(w, e, d);
	endtask

	// Settings change only with reception stopped
	task automatic cfg(input logic [31:0] v, input logic en);
		wr(OFF_REN, 32'h0000_0000);
		rchk("enable", OFF_REN, 32'h0000_0000);
		wr(OFF_RCR1, v);
		wr(OFF_REN, {31'h0, en});
	endtask

	initial begin
		logic [31:0] d;
		logic [1:0]  r;
		{awvalid, wvalid, bready, arvalid, rready} = 5'h00;
		{awaddr, araddr, wdata, wstrb} = {8'h00, 8'h00, 32'h0000_0000, 4'hF};
		aresetn = 1'b0;
		repeat (10) @(posedge aclk);
		aresetn <= 1'b1;
		// ****************************************
		// Registers: reset values, writable bits, unmapped place
		// ****************************************
		rchk("rcr1 reset", OFF_RCR1, RCR1_RESET);
		cmp("irq reset", 32'h0, 32'(irq));
		cmp("cec_out", 32'h0, 32'(cec_out));
		cfg(32'hFFFF_FFFF, 1'b0);
		rchk("rcr1 bits", OFF_RCR1, RCR1_WMASK);
		axw(8'h20, 32'h1234_5678, r);
		cmp("unmapped bresp", 32'(RESP_SLVERR), 32'(r));
		axr(8'h20, d, r);
		cmp("unmapped rresp", 32'(RESP_SLVERR), 32'(r));
		cmp("unmapped rdata", 32'h0, d);
		wr(OFF_MASK, 32'h0000_0007);
		// ****************************************
		// Glitch filters at codes 1 to 3, seen on the ack sampling output
		// ****************************************
		for (int k = 1; k < 4; k++) begin
			cfg((32'(k) << HNC_LSB) | (32'(k) << LNC_LSB), 1'b0);
			e0 = tx_edges;
			mdl.level(1'b0, k);
			mdl.level(1'b1, 8);
			cmp("short low", 32'(e0), 32'(tx_edges));
			mdl.level(1'b0, k + 1);
			mdl.level(1'b1, 8);
			cmp("full low", 32'(e0 + 2), 32'(tx_edges));
			mdl.level(1'b0, 8);
			mdl.level(1'b1, k);
			mdl.level(1'b0, 8);
			mdl.level(1'b1, 8);
			cmp("short high", 32'(e0 + 4), 32'(tx_edges));
		end
		// ****************************************
		// Minimum period: code 001 gives 68, 68 passes and 67 fails
		// ****************************************
		cfg(32'h0000_1000, 1'b1);
		runs = 0;
		mdl.bit_s(120, 140, s);
		mdl.bit_s(20, 68, s);
		mdl.bit_s(20, 67, s);
		mdl.level(1'b0, 3);
		mdl.level(1'b1, 20);
		cmp("error low runs", 32'h1, 32'(runs));
		cmp("error low length", 32'(ERR_CYC), 32'(last_run));
		rchk("status min", OFF_STAT, 32'h0000_0001);
		cmp("irq min", 32'h1, 32'(irq));
		wr(OFF_STAT, 32'h0000_0001);
		rchk("status clear", OFF_STAT, 32'h0);
		cmp("irq clear", 32'h0, 32'(irq));
		// ****************************************
		// Maximum period: code 111 gives 86
		// ****************************************
		cfg(32'h0000_0700, 1'b1);
		mdl.bit_s(120, 140, s);
		mdl.level(1'b0, 20);
		mdl.level(1'b1, 63);
		rchk("status before max", OFF_STAT, 32'h0);
		mdl.level(1'b1, 10);
		rchk("status max", OFF_STAT, 32'h0000_0002);
		cmp("irq max", 32'h1, 32'(irq));
		wr(OFF_MASK, 32'h0000_0000);
		cmp("irq masked", 32'h0, 32'(irq));
		wr(OFF_STAT, 32'h0000_0007);
		// ****************************************
		// Ack of header and data blocks, suppress set then clear
		// ****************************************
		wr(OFF_ADDR, 32'h0000_0008);
		for (int k = 1; k >= 0; k--) begin
			cfg(32'(k) << ACKDIS_POS, 1'b1);
			mdl.level(1'b1, 20);
			mdl.bit_s(120, 140, s);
			mdl.blk(8'h43, 1'b0, s);
			cmp("header ack", 32'h0, 32'(s));
			mdl.blk(8'h5A, 1'b1, s);
			cmp("data ack", 32'(k), 32'(s));
			rchk("rx data", OFF_RXDATA, 32'h0000_015A | (32'(k) << 9));
		end
		conclude();
	end
endmodule // tb_top
